// [inc/ddr3_pin_pkg.sv]
`default_nettype none
package ddr3_pin_pkg;

    // ------------------------------------------------------------------
    // Geometry and pin fields
    // ------------------------------------------------------------------
    localparam int         BANKS     = 8;
    localparam int         BA_W      = 3;
    localparam int         ADDR_W    = 16;
    localparam int         AUTO_PRE_BIT    = 10;
    localparam int         TERM_STROBE_BIT = 11;
    localparam int         CHOP_BIT        = 12;
    localparam logic [2:0] MODE_ONE_SEL    = 3'h1;

    // ------------------------------------------------------------------
    // Timing, in link clock cycles unless named otherwise
    // ------------------------------------------------------------------
    localparam logic [3:0] BURST_LEN = 4'h8;
    localparam logic [3:0] CHOP_LEN  = 4'h4;
    localparam int         RD_LAT    = 2;
    localparam int         WR_LAT    = 1;
    localparam int         LINK_DIV  = 4;
    localparam logic [4:0] RD_SLOTS  = 5'h0b;
    localparam logic [4:0] WR_SLOTS  = 5'h09;
    localparam logic [4:0] CMD_SLOTS = 5'h01;

    typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_MRS} cmd_type;

    // Row, column and write strobe pins as {ras_n, cas_n, we_n}
    function automatic cmd_type decode_cmd(input logic cs_n, input logic [2:0] rcw);
        if (cs_n) begin
            return CMD_NOP; // R11
        end
        case (rcw)
            3'h3:    return CMD_ACT;
            3'h5:    return CMD_RD;
            3'h4:    return CMD_WR;
            3'h2:    return CMD_PRE;
            3'h0:    return CMD_MRS;
            default: return CMD_NOP;
        endcase
    endfunction

    function automatic logic [2:0] encode_cmd(input cmd_type c);
        case (c)
            CMD_ACT: return 3'h3;
            CMD_RD:  return 3'h5;
            CMD_WR:  return 3'h4;
            CMD_PRE: return 3'h2;
            CMD_MRS: return 3'h0;
            default: return 3'h7;
        endcase
    endfunction

endpackage
`default_nettype wire

// [inc/ddr3_link_if.sv]
`default_nettype none
interface ddr3_link_if #(
    parameter int DATA_W = 16
) ();
    localparam int LANES = DATA_W / 8;

    logic              link_clk;
    logic              reset_n;
    logic              cs_n;
    logic [2:0]        rcw_n;
    logic [2:0]        ba;
    logic [15:0]       addr;
    logic              odt;
    logic [DATA_W-1:0] dq_h2d;
    logic              dq_oe_h;
    logic [DATA_W-1:0] dq_d2h;
    logic              dq_oe_d;
    logic [LANES-1:0]  dqs_h2d;
    logic [LANES-1:0]  dqs_d2h;
    logic [LANES-1:0]  write_mask;
    logic              term_strobe;

    // ------------------------------------------------------------------
    // Shared wire levels, worked out from the two enables
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] dq_line;
    logic [LANES-1:0]  dqs_t_line;
    logic [LANES-1:0]  dqs_c_line;

    assign dq_line    = dq_oe_h ? dq_h2d : (dq_oe_d ? dq_d2h : '0);
    assign dqs_t_line = dq_oe_h ? dqs_h2d : (dq_oe_d ? dqs_d2h : '0);
    assign dqs_c_line = ~dqs_t_line;

    modport ctl (
        output link_clk, reset_n, cs_n, rcw_n, ba, addr, odt,
        output dq_h2d, dq_oe_h, dqs_h2d, write_mask,
        input  dq_d2h, dq_oe_d, dqs_d2h, term_strobe
    );

    modport dev (
        input  link_clk, reset_n, cs_n, rcw_n, ba, addr, odt,
        input  dq_h2d, dq_oe_h, dqs_h2d, write_mask,
        output dq_d2h, dq_oe_d, dqs_d2h, term_strobe
    );
endinterface
`default_nettype wire

// [rtl/ddr3_ctl_end.sv]
// The plain strobed command port was decided locally.
`default_nettype none
module ddr3_ctl_end #(
    parameter int DATA_W = 16,
    parameter int DIV    = ddr3_pin_pkg::LINK_DIV
) (
    input  wire logic                   clk_sys,
    input  wire logic                   rstn,
    ddr3_link_if.ctl                    lnk,
    input  wire logic                   cmd_valid,
    input  wire ddr3_pin_pkg::cmd_type  cmd_code,
    input  wire logic [2:0]             cmd_bank,
    input  wire logic [15:0]            cmd_addr,
    input  wire logic [DATA_W-1:0]      wr_data,
    input  wire logic [7:0]             wr_beat_mask,
    input  wire logic                   odt_req,
    input  wire logic                   dev_reset_req,
    output logic                        cmd_ready,
    output logic [DATA_W-1:0]           rd_data,
    output logic                        rd_valid
);
    localparam int         LANES = DATA_W / 8;
    localparam logic [7:0] HALF  = 8'(DIV / 2);
    localparam logic [7:0] LAST  = 8'(DIV - 1);

    typedef enum logic [1:0] {C_IDLE, C_ISSUE, C_BUSY} cst_type;

    typedef struct packed {
        logic [7:0]        div;
        logic              link_clk;
        cst_type           st;
        logic              is_wr;
        logic              is_rd;
        logic [4:0]        slot;
        logic [4:0]        slot_end;
        logic              cs_n;
        logic [2:0]        rcw_n;
        logic [2:0]        cmd_rcw;
        logic [2:0]        ba;
        logic [15:0]       addr;
        logic              odt;
        logic              reset_n;
        logic [DATA_W-1:0] dq_out;
        logic              dq_oe;
        logic [LANES-1:0]  dqs;
        logic [LANES-1:0]  mask;
        logic [DATA_W-1:0] wdata;
        logic [7:0]        beat_mask;
        logic              ready;
        logic [DATA_W-1:0] rd_data;
        logic              rd_valid;
        logic [DATA_W-1:0] dq_s1;
        logic [DATA_W-1:0] dq_s2;
        logic [LANES-1:0]  dqs_s1;
        logic [LANES-1:0]  dqs_s2;
        logic [LANES-1:0]  dqs_last;
    } ctl_state_type;

    ctl_state_type s_r;
    ctl_state_type s_nxt;
    logic          tick;

    always_comb begin
        s_nxt = s_r;
        // Link clock made here: cs_n, rcw_n, dq, dqs and mask move on its falling edge; ba, addr, odt on any clk_sys edge
        tick           = (s_r.div == HALF - 8'h01);
        s_nxt.div      = (s_r.div == LAST) ? 8'h00 : s_r.div + 8'h01;
        s_nxt.link_clk = (s_nxt.div < HALF);
        s_nxt.reset_n  = ~dev_reset_req; // R5
        s_nxt.odt      = odt_req;
        s_nxt.dq_s1    = lnk.dq_d2h;
        s_nxt.dq_s2    = s_r.dq_s1;
        s_nxt.dqs_s1   = lnk.dqs_d2h;
        s_nxt.dqs_s2   = s_r.dqs_s1;
        s_nxt.dqs_last = s_r.dqs_s2;
        s_nxt.rd_valid = 1'b0;
        for (int l = 0; l < LANES; l++) begin
            if (s_r.is_rd && (s_r.dqs_s2[l] != s_r.dqs_last[l])) begin
                s_nxt.rd_data[l*8 +: 8] = s_r.dq_s2[l*8 +: 8]; // R8
                s_nxt.rd_valid          = 1'b1;
            end
        end
        case (s_r.st)
            C_IDLE: begin
                if (cmd_valid && s_r.ready) begin
                    s_nxt.ready     = 1'b0;
                    s_nxt.st        = C_ISSUE;
                    s_nxt.is_wr     = (cmd_code == ddr3_pin_pkg::CMD_WR);
                    s_nxt.is_rd     = (cmd_code == ddr3_pin_pkg::CMD_RD);
                    s_nxt.cmd_rcw   = ddr3_pin_pkg::encode_cmd(cmd_code);
                    s_nxt.wdata     = wr_data;
                    s_nxt.beat_mask = wr_beat_mask;
                    s_nxt.slot_end  = ddr3_pin_pkg::CMD_SLOTS;
                    if (cmd_code == ddr3_pin_pkg::CMD_WR) begin
                        s_nxt.slot_end = ddr3_pin_pkg::WR_SLOTS;
                    end else if (cmd_code == ddr3_pin_pkg::CMD_RD) begin
                        s_nxt.slot_end = ddr3_pin_pkg::RD_SLOTS;
                    end
                    s_nxt.ba   = cmd_bank; // R3 R13
                    s_nxt.addr = cmd_addr;
                end
            end
            C_ISSUE: begin
                if (tick) begin
                    s_nxt.cs_n  = 1'b0;
                    s_nxt.rcw_n = s_r.cmd_rcw;
                    s_nxt.slot  = 5'h00;
                    s_nxt.st    = C_BUSY;
                end
            end
            C_BUSY: begin
                if (tick) begin
                    s_nxt.cs_n  = 1'b1;
                    s_nxt.rcw_n = 3'h7;
                    s_nxt.dq_oe = 1'b0;
                    // Full eight slots even when chopped: device stays busy
                    if (s_r.is_wr && (s_r.slot < 5'(ddr3_pin_pkg::BURST_LEN))) begin
                        s_nxt.dq_out = s_r.wdata + DATA_W'(s_r.slot);
                        s_nxt.dq_oe  = 1'b1;
                        s_nxt.dqs    = ~s_r.dqs; // R7 R14
                        s_nxt.mask   = {LANES{s_r.beat_mask[s_r.slot[2:0]]}};
                    end
                    s_nxt.slot = s_r.slot + 5'h01;
                    if (s_r.slot == s_r.slot_end - 5'h01) begin
                        s_nxt.st    = C_IDLE;
                        s_nxt.ready = 1'b1;
                        s_nxt.is_rd = 1'b0;
                        s_nxt.is_wr = 1'b0;
                    end
                end
            end
            default: s_nxt.st = C_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_r          <= '0;
            s_r.link_clk <= 1'b1;
            s_r.cs_n     <= 1'b1;
            s_r.rcw_n    <= 3'h7;
            s_r.ready    <= 1'b1;
            s_r.st       <= C_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign lnk.link_clk   = s_r.link_clk;
    assign lnk.reset_n    = s_r.reset_n;
    assign lnk.cs_n       = s_r.cs_n;
    assign lnk.rcw_n      = s_r.rcw_n;
    assign lnk.ba         = s_r.ba;
    assign lnk.addr       = s_r.addr;
    assign lnk.odt        = s_r.odt;
    assign lnk.dq_h2d     = s_r.dq_out;
    assign lnk.dq_oe_h    = s_r.dq_oe;
    assign lnk.dqs_h2d    = s_r.dqs;
    assign lnk.write_mask = s_r.mask;
    assign cmd_ready      = s_r.ready;
    assign rd_data        = s_r.rd_data;
    assign rd_valid       = s_r.rd_valid;
endmodule
`default_nettype wire

// [rtl/ddr3_dev_end.sv]
// Notes on behaviour
// R1: Read/write bit 10 high closes bank after
// R2: Precharge bit 10: low one bank, high all
// R3: Single-bank precharge hits only the addressed bank
// R4: Read/write bit 12 low chops the burst
// R5: Reset pin low resets asynchronously; high normally
// R6: Read strobe driven out, edges with data
// R7: Write strobe from controller, edge-aligned with data; the controller toggles it on the same edge as the data
// R8: Each byte lane has its own strobe
// R9: Termination strobe terminated when bit 11 set
// R10: Bit 11 clear: mask pin masks writes
// R11: Chip select high ignores the command
// R12: Masked write beats are not stored
// R13: Bank inputs pick bank or mode register
// R14: Chopped burst moves four beats, eight slots
`default_nettype none
module ddr3_dev_end #(
    parameter int DATA_W = 16,
    parameter int ROW_W  = 2,
    parameter int COL_W  = 4
) (
    ddr3_link_if.dev               lnk,
    output logic [7:0]             bank_open,
    output logic                   term_strobe_on,
    output logic                   mask_on
);
    localparam int LANES = DATA_W / 8;
    localparam bit X8    = (DATA_W == 8);
    localparam int MA_W  = ddr3_pin_pkg::BA_W + ROW_W + COL_W;
    localparam int DEPTH = 2 ** MA_W;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_RD_WAIT, ST_RD, ST_WR} st_type;

    typedef struct packed {
        st_type                                  st;
        logic [ddr3_pin_pkg::BANKS-1:0]          bank_open;
        logic [ddr3_pin_pkg::BANKS-1:0][ROW_W-1:0] open_row;
        logic                                    term_strobe_en;
        logic [3:0]                              wait_cnt;
        logic [3:0]                              beat;
        logic                                    chop;
        logic                                    auto_pre;
        logic [2:0]                              bank;
        logic [ROW_W-1:0]                        row;
        logic [COL_W-1:0]                        col;
        logic [DATA_W-1:0]                       dq_out;
        logic                                    dq_oe;
        logic [LANES-1:0]                        dqs;
        logic [LANES-1:0]                        dqs_seen;
        logic                                    term_on;
        logic                                    mask_on;
    } dev_state_type;

    dev_state_type          s_r;
    dev_state_type          s_nxt;
    ddr3_pin_pkg::cmd_type  cmd;
    logic [3:0]             burst_len;
    logic                   live;
    logic [MA_W-1:0]        mem_addr;
    logic [COL_W-1:0]       col_now;
    logic [LANES-1:0]       wr_lane;
    logic                   finish;

    // Backing store, no reset: contents survive a pin reset
    logic [DATA_W-1:0]      mem [DEPTH];

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt     = s_r;
        cmd       = ddr3_pin_pkg::decode_cmd(lnk.cs_n, lnk.rcw_n); // R11
        burst_len = s_r.chop ? ddr3_pin_pkg::CHOP_LEN : ddr3_pin_pkg::BURST_LEN; // R14
        live      = (s_r.beat < burst_len);
        // Burst wraps inside its aligned block of eight columns
        col_now   = {s_r.col[COL_W-1:3], s_r.col[2:0] + s_r.beat[2:0]};
        mem_addr  = {s_r.bank, s_r.row, col_now};
        wr_lane   = '0;
        finish    = 1'b0;

        s_nxt.dqs_seen = lnk.dqs_h2d;
        s_nxt.dq_oe    = 1'b0;
        // Only the narrow part has a termination strobe
        s_nxt.term_on  = lnk.odt && s_r.term_strobe_en && X8; // R9
        s_nxt.mask_on  = !(X8 && s_r.term_strobe_en); // R10

        case (s_r.st)
            ST_IDLE: begin
                case (cmd)
                    ddr3_pin_pkg::CMD_ACT: begin
                        s_nxt.bank_open[lnk.ba] = 1'b1; // R13
                        s_nxt.open_row[lnk.ba]  = lnk.addr[ROW_W-1:0];
                    end
                    ddr3_pin_pkg::CMD_PRE: begin
                        if (lnk.addr[ddr3_pin_pkg::AUTO_PRE_BIT]) begin
                            s_nxt.bank_open = '0; // R2
                        end else begin
                            s_nxt.bank_open[lnk.ba] = 1'b0; // R2 R3
                        end
                    end
                    ddr3_pin_pkg::CMD_MRS: begin
                        if (lnk.ba == ddr3_pin_pkg::MODE_ONE_SEL) begin
                            s_nxt.term_strobe_en = lnk.addr[ddr3_pin_pkg::TERM_STROBE_BIT]; // R13
                        end
                    end
                    ddr3_pin_pkg::CMD_RD,
                    ddr3_pin_pkg::CMD_WR: begin
                        s_nxt.bank     = lnk.ba; // R13
                        s_nxt.row      = s_r.open_row[lnk.ba];
                        s_nxt.col      = lnk.addr[COL_W-1:0];
                        s_nxt.chop     = !lnk.addr[ddr3_pin_pkg::CHOP_BIT]; // R4
                        s_nxt.auto_pre = lnk.addr[ddr3_pin_pkg::AUTO_PRE_BIT]; // R1
                        s_nxt.beat     = 4'h0;
                        s_nxt.wait_cnt = 4'h0;
                        if (cmd == ddr3_pin_pkg::CMD_RD) begin
                            s_nxt.st = ST_RD_WAIT;
                        end else begin
                            s_nxt.st = ST_WR;
                        end
                    end
                    default: begin
                    end
                endcase
            end

            ST_RD_WAIT: begin
                s_nxt.wait_cnt = s_r.wait_cnt + 4'h1;
                // Entering the read state costs one cycle of the latency
                if (s_r.wait_cnt == 4'(ddr3_pin_pkg::RD_LAT - 2)) begin
                    s_nxt.st = ST_RD;
                end
            end

            ST_RD: begin
                // Data and strobe change on the same edge
                if (live) begin
                    s_nxt.dq_out = mem[mem_addr]; // R6
                    s_nxt.dq_oe  = 1'b1;
                    s_nxt.dqs    = ~s_r.dqs; // R6 R8
                end
                s_nxt.beat = s_r.beat + 4'h1;
                finish     = (s_r.beat == ddr3_pin_pkg::BURST_LEN - 4'h1); // R14
            end

            ST_WR: begin
                // Each lane stores only on a toggle of its own strobe
                for (int l = 0; l < LANES; l++) begin
                    if (live && (lnk.dqs_h2d[l] != s_r.dqs_seen[l])
                        && !(s_r.mask_on && lnk.write_mask[l])) begin
                        wr_lane[l] = 1'b1; // R7 R8 R12 R14
                    end
                end
                s_nxt.beat = s_r.beat + 4'h1;
                finish     = (s_r.beat == ddr3_pin_pkg::BURST_LEN - 4'h1);
            end

            default: s_nxt.st = ST_IDLE;
        endcase

        if (finish) begin
            s_nxt.st = ST_IDLE;
            if (s_r.auto_pre) begin
                s_nxt.bank_open[s_r.bank] = 1'b0; // R1
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge lnk.link_clk or negedge lnk.reset_n) begin
        if (!lnk.reset_n) begin
            s_r         <= '0; // R5
            s_r.st      <= ST_IDLE;
            s_r.mask_on <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    always_ff @(posedge lnk.link_clk) begin
        for (int l = 0; l < LANES; l++) begin
            if (wr_lane[l]) begin
                mem[mem_addr][l*8 +: 8] <= lnk.dq_h2d[l*8 +: 8];
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign lnk.dq_d2h    = s_r.dq_out;
    assign lnk.dq_oe_d   = s_r.dq_oe;
    assign lnk.dqs_d2h   = s_r.dqs;
    assign lnk.term_strobe = s_r.term_on;
    assign bank_open     = s_r.bank_open;
    assign term_strobe_on = s_r.term_on;
    assign mask_on       = s_r.mask_on;
endmodule
`default_nettype wire

// [verif/ddr3_pin_asserts.sv]
`default_nettype none
module ddr3_pin_asserts #(
    parameter int DATA_W = 16,
    parameter int LANES  = DATA_W / 8
) (
    input wire logic              link_clk,
    input wire logic              reset_n,
    input wire logic              cs_n,
    input wire logic [2:0]        rcw_n,
    input wire logic [15:0]       addr,
    input wire logic              dq_oe_h,
    input wire logic              dq_oe_d,
    input wire logic [DATA_W-1:0] dq_d2h,
    input wire logic [LANES-1:0]  dqs_h2d,
    input wire logic [LANES-1:0]  dqs_d2h,
    input wire logic              term_strobe
);
    timeunit 1ns;
    timeprecision 1ps;

    logic rd_cmd;
    logic wr_cmd;

    assign rd_cmd = !cs_n && (rcw_n == 3'h5);
    assign wr_cmd = !cs_n && (rcw_n == 3'h4);

    default clocking cb @(posedge link_clk);
    endclocking
    default disable iff (!reset_n);

    // ------------------------------------------------------------------
    // Link checks
    // ------------------------------------------------------------------
    chk_no_bus_fight: assert property (!(dq_oe_h && dq_oe_d))
        else $error("both ends drive the data lines");
    chk_rd_oe_start: assert property (rd_cmd |-> ##3 dq_oe_d)
        else $error("read data not driven after read latency");
    chk_rd_full_burst: assert property (
        rd_cmd && addr[12] |-> ##3 (dqs_d2h == ~$past(dqs_d2h))[*8])
        else $error("full read burst lacks eight strobe edges per lane");
    chk_rd_chop_stop: assert property (
        rd_cmd && !addr[12] |-> ##3 (dqs_d2h == ~$past(dqs_d2h))[*4]
        ##1 $stable(dqs_d2h)[*4])
        else $error("chopped read strobe count wrong");
    chk_rd_edge_align: assert property (
        dq_oe_d && $changed(dq_d2h) |-> $changed(dqs_d2h))
        else $error("read data moved without a strobe edge");
    chk_wr_window: assert property (wr_cmd |-> ##1 dq_oe_h[*8] ##1 !dq_oe_h)
        else $error("write data window is not eight beats");
    chk_wr_strobe_lanes: assert property (
        wr_cmd |-> ##1 (dqs_h2d == ~$past(dqs_h2d))[*8])
        else $error("write strobe missed a beat on some lane");
    chk_term_wide: assert property ((DATA_W == 8) || !term_strobe)
        else $error("termination strobe active in wide configuration");
    chk_reset_quiet: assert property (disable iff (1'b0) !reset_n |-> !dq_oe_d)
        else $error("device drives data while held in reset");

    cov_full_read: cover property (rd_cmd && addr[12]);
    cov_chop_read: cover property (rd_cmd && !addr[12]);
    cov_write: cover property (wr_cmd ##1 dq_oe_h);
    cov_pre_all: cover property (!cs_n && (rcw_n == 3'h2) && addr[10]);
endmodule
`default_nettype wire

// [verif/ddr3_pin_function_decode_tb.sv]
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD %s expected %0h seen %0h", nm, e, g); end end

module ddr3_pin_function_decode_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  clk_sys;
    logic                  rstn;
    logic                  cmd_valid;
    ddr3_pin_pkg::cmd_type cmd_code;
    logic [2:0]            cmd_bank;
    logic [15:0]           cmd_addr;
    logic [15:0]           wr_data;
    logic [7:0]            wr_beat_mask;
    logic                  odt_req;
    logic                  dev_reset_req;
    logic                  cmd_ready;
    logic [15:0]           rd_data;
    logic                  rd_valid;
    logic [7:0]            bank_open;
    logic                  term_strobe_on;
    logic                  mask_on;
    int                    n_fail;
    int                    compares;
    int                    cycles;
    logic [15:0]           beats[$];

    ddr3_link_if #(.DATA_W(16)) ddr3_link_if_inst ();

    ddr3_ctl_end #(.DATA_W(16), .DIV(ddr3_pin_pkg::LINK_DIV)) ddr3_ctl_end_inst (
        .clk_sys       (clk_sys),
        .rstn          (rstn),
        .lnk           (ddr3_link_if_inst),
        .cmd_valid     (cmd_valid),
        .cmd_code      (cmd_code),
        .cmd_bank      (cmd_bank),
        .cmd_addr      (cmd_addr),
        .wr_data       (wr_data),
        .wr_beat_mask  (wr_beat_mask),
        .odt_req       (odt_req),
        .dev_reset_req (dev_reset_req),
        .cmd_ready     (cmd_ready),
        .rd_data       (rd_data),
        .rd_valid      (rd_valid)
    );

    ddr3_dev_end #(.DATA_W(16)) ddr3_dev_end_inst (
        .lnk            (ddr3_link_if_inst),
        .bank_open      (bank_open),
        .term_strobe_on (term_strobe_on),
        .mask_on        (mask_on)
    );

    ddr3_pin_asserts #(.DATA_W(16)) ddr3_pin_asserts_inst (
        .link_clk  (ddr3_link_if_inst.link_clk),
        .reset_n   (ddr3_link_if_inst.reset_n),
        .cs_n      (ddr3_link_if_inst.cs_n),
        .rcw_n     (ddr3_link_if_inst.rcw_n),
        .addr      (ddr3_link_if_inst.addr),
        .dq_oe_h   (ddr3_link_if_inst.dq_oe_h),
        .dq_oe_d   (ddr3_link_if_inst.dq_oe_d),
        .dq_d2h    (ddr3_link_if_inst.dq_d2h),
        .dqs_h2d   (ddr3_link_if_inst.dqs_h2d),
        .dqs_d2h   (ddr3_link_if_inst.dqs_d2h),
        .term_strobe (ddr3_link_if_inst.term_strobe)
    );

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Beats land in the queue as the controller hands them over
    always @(posedge clk_sys) begin
        if (rd_valid === 1'b1) begin
            beats.push_back(rd_data);
        end
    end

    // Some 13 commands of about 20 to 60 cycles each
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Returns after the command window plus a drain for trailing beats
    task automatic issue(input ddr3_pin_pkg::cmd_type c, input logic [2:0] b,
                         input logic [15:0] a);
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_code  <= c;
        cmd_bank  <= b;
        cmd_addr  <= a;
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        while (cmd_ready !== 1'b1) begin
            @(posedge clk_sys);
            #1;
        end
        repeat (12) @(posedge clk_sys);
        #1;
    endtask

    task automatic write_burst(input logic [15:0] a, input logic [15:0] base,
                               input logic [7:0] m);
        @(posedge clk_sys);
        wr_data      <= base;
        wr_beat_mask <= m;
        issue(ddr3_pin_pkg::CMD_WR, 3'h2, a);
    endtask

    task automatic read_check(input logic [15:0] a, input int nb, input logic [15:0] base,
                              input int mb, input logic [15:0] mv);
        logic [15:0] e;
        beats.delete();
        issue(ddr3_pin_pkg::CMD_RD, 3'h2, a);
        `CHK("beat count", nb, beats.size())
        for (int i = 0; i < nb && i < beats.size(); i++) begin
            e = (i == mb) ? mv : base + 16'(i);
            `CHK("read beat", e, beats[i])
        end
    endtask

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        rstn          = 1'b0;
        cmd_valid     = 1'b0;
        cmd_code      = ddr3_pin_pkg::CMD_NOP;
        cmd_bank      = 3'h0;
        cmd_addr      = 16'h0000;
        wr_data       = 16'h0000;
        wr_beat_mask  = 8'h00;
        odt_req       = 1'b0;
        dev_reset_req = 1'b0;
        n_fail        = 0;
        compares      = 0;
        cycles        = 0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        issue(ddr3_pin_pkg::CMD_ACT, 3'h2, 16'h0005);
        `CHK("bank open", 8'h04, bank_open)
        write_burst(16'h1000, 16'h2000, 8'h00);
        write_burst(16'h1000, 16'h1000, 8'h04);
        `CHK("bank open", 8'h04, bank_open)
        read_check(16'h1000, 8, 16'h1000, 2, 16'h2002);
        `CHK("bank open", 8'h04, bank_open)
        read_check(16'h0400, 4, 16'h1000, 2, 16'h2002);
        `CHK("bank open", 8'h00, bank_open)
        issue(ddr3_pin_pkg::CMD_ACT, 3'h1, 16'h0001);
        issue(ddr3_pin_pkg::CMD_ACT, 3'h3, 16'h0002);
        `CHK("bank open", 8'h0a, bank_open)
        issue(ddr3_pin_pkg::CMD_PRE, 3'h1, 16'h0000);
        `CHK("bank open", 8'h08, bank_open)
        issue(ddr3_pin_pkg::CMD_ACT, 3'h5, 16'h0003);
        issue(ddr3_pin_pkg::CMD_PRE, 3'h0, 16'h0400);
        `CHK("bank open", 8'h00, bank_open)
        @(posedge clk_sys);
        odt_req <= 1'b1;
        issue(ddr3_pin_pkg::CMD_MRS, ddr3_pin_pkg::MODE_ONE_SEL, 16'h0800);
        `CHK("term strobe", 1'b0, term_strobe_on)
        `CHK("mask honoured", 1'b1, mask_on)
        issue(ddr3_pin_pkg::CMD_ACT, 3'h6, 16'h0001);
        @(posedge clk_sys);
        dev_reset_req <= 1'b1;
        repeat (8) @(posedge clk_sys);
        #1;
        `CHK("bank open", 8'h00, bank_open)
        @(posedge clk_sys);
        dev_reset_req <= 1'b0;
        repeat (8) @(posedge clk_sys);
        issue(ddr3_pin_pkg::CMD_ACT, 3'h7, 16'h0001);
        `CHK("bank open", 8'h80, bank_open)
        tally_and_finish();
    end
endmodule
`default_nettype wire
